/* File: common/nac_params.svh */
/*
 Timing counts, widths and reset values of the node address and clock setup block.
 Assumes it is included by bare name wherever these macros are used.
*/
`ifndef NAC_PARAMS_SVH
`define NAC_PARAMS_SVH

`define NAC_SLOW_MHZ     40
`define NAC_FAST_MHZ     80
`define NAC_BIT_NS       1000
`define NAC_BIT_TICKS    ((`NAC_BIT_NS * `NAC_SLOW_MHZ) / 1000)
`define NAC_GAP_BITS     2
`define NAC_ADDR_W       6
`define NAC_ADDR_RST     6'h00
`define NAC_ADDR_MAX     6'h3f
`define NAC_RST_MIN_CYC  10
`define NAC_CONFIRM_US   50

`endif

/* File: common/nac_pkg.sv */
/*
 Types of the node address and clock setup block.
 Assumes nac_params.svh is on the include path.
*/
`include "nac_params.svh"

package nac_pkg;

	typedef enum logic [1:0] {
		NAC_IDLE  = 2'h0,
		NAC_START = 2'h1,
		NAC_DATA  = 2'h3,
		NAC_STOP  = 2'h2
	} nac_ser_t;

	typedef struct packed {
		logic                   clk_rate_select;
		logic                   addr_method_select;
		logic                   break_frame_request;
		logic [`NAC_ADDR_W-1:0] addr_strap_n;
	} nac_pins_t;

endpackage

/* File: verilog/nac_clk_div.sv */
/*
 Divide-by-two of the fast reference clock into a working clock and its tick.
 Assumes a reset already released synchronously to i_clk.
*/
`timescale 1ns/1ps

module nac_clk_div (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_fast,
	output logic      o_work_clk,
	output logic      o_tick
);

	logic phase_reg;
	logic phase_next;

	// Toggle every rising edge in fast mode, held low in slow mode: a balanced duty cycle whatever the input duty
	always_comb begin
		phase_next = i_fast ? ~phase_reg : 1'b0; // RULE17
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign o_work_clk = phase_reg;
	// Fast rate works on every other edge, slow rate on every edge
	assign o_tick     = !i_fast || phase_reg; // RULE2

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_div_toggle: assert property (i_fast && $past(i_fast) |=> o_work_clk != $past(o_work_clk)) // RULE17
		else $error("Working clock did not toggle in fast mode");
	a_div_half: assert property (i_fast && $past(i_fast) |-> ##1 (o_tick != $past(o_tick))) // RULE2
		else $error("Fast mode tick is not every other cycle");

endmodule

/* File: verilog/nac_node_cfg.sv */
/*
 Start-up configuration of a network node: clock rate, reset qualifying,
 node address from straps or from the address chain, and the chain output.
 Assumes strap and chain pins are asynchronous; the reset pin is held low
 for more than ten clock cycles with the clock running.
*/
`timescale 1ns/1ps
`include "nac_params.svh"

// Rules for this block and its board
// RULE1: Rate strap selects slow or fast reference.
// RULE2: Fast reference divided down to slow rate.
// RULE3: Bit rate independent of reference rate choice.
// RULE4: Low reset resets all, released synchronously.
// RULE5: Reset held over ten cycles, clock running.
// RULE6: Address straps are active low.
// RULE7: Method high: address from parallel straps.
// RULE8: Method low: serial address on bit 0.
// RULE9: Serial mode address is received plus one.
// RULE10: Board grounds straps 1 to 5 serially.
// RULE11: Accept only two identical consecutive frames.
// RULE12: Active-low chain output sends next address.
// RULE13: Active-high break frame request input.
// RULE14: Chain sends own address plus one, wrapping.
// RULE15: Allow about 50 us per chain node.
// RULE16: Hold address until confirmed; reset clears match.
// RULE17: Fast reference divided by two, balanced duty.
module nac_node_cfg #(
	parameter int BIT_TICKS = `NAC_BIT_TICKS,
	parameter int GAP_BITS  = `NAC_GAP_BITS
) (
	input  wire logic                   I_CLK,
	input  wire logic                   I_RST_N,
	input  wire logic                   I_CLK_RATE_SELECT,
	input  wire logic                   I_ADDR_METHOD_SELECT,
	input  wire logic [`NAC_ADDR_W-1:0] I_ADDR_STRAP_N,
	input  wire logic                   I_BREAK_FRAME_REQUEST,
	output logic                        O_WORK_CLK,
	output logic                        O_FAST_RATE,
	output logic                        O_RST_N,
	output logic [`NAC_ADDR_W-1:0]      O_NODE_ADDR,
	output logic                        O_ADDR_VALID,
	output logic                        O_ADDR_CHAIN_OUT_N,
	output logic                        O_BIT_STROBE,
	output logic                        O_BREAK_REQ
);

	if (BIT_TICKS < 4 || BIT_TICKS > 255) begin : g_bad_bit
		$error("BIT_TICKS must lie in 4..255");
	end
	if (GAP_BITS < 1 || GAP_BITS > 8) begin : g_bad_gap
		$error("GAP_BITS must lie in 1..8");
	end

	localparam logic [7:0] BIT_M1    = 8'(BIT_TICKS - 1);
	localparam logic [7:0] HALF_M1   = 8'(BIT_TICKS / 2 - 1);
	localparam logic [2:0] GAP_M1    = 3'(GAP_BITS - 1);
	localparam logic [2:0] DATA_LAST = 3'(`NAC_ADDR_W - 1);

	// Reset: asserted at once, released on the clock
	logic rst_q1_reg;
	logic rst_q2_reg;
	logic rst_n_int;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_q1_reg <= 1'b0; // RULE4
			rst_q2_reg <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_q2_reg <= rst_q1_reg;
		end
	end
	assign rst_n_int = rst_q2_reg;
	assign O_RST_N   = rst_q2_reg;

	// Pin synchronisers; only the second stage is read
	nac_pkg::nac_pins_t pins_raw;
	nac_pkg::nac_pins_t pins_s1_reg;
	nac_pkg::nac_pins_t pins;

	assign pins_raw = '{clk_rate_select:     I_CLK_RATE_SELECT,
	                    addr_method_select:  I_ADDR_METHOD_SELECT,
	                    break_frame_request: I_BREAK_FRAME_REQUEST,
	                    addr_strap_n:        I_ADDR_STRAP_N};

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pins_s1_reg <= '0;
			pins        <= '0;
		end else begin
			pins_s1_reg <= pins_raw;
			pins        <= pins_s1_reg;
		end
	end

	logic tick;

	nac_clk_div i_nac_clk_div (
		.i_clk      (I_CLK),
		.i_rst_n    (rst_n_int),
		.i_fast     (pins.clk_rate_select), // RULE1
		.o_work_clk (O_WORK_CLK),
		.o_tick     (tick)
	);
	assign O_FAST_RATE = pins.clk_rate_select;

	// Break request passes straight through, registered
	logic brk_reg;
	always_ff @(posedge I_CLK or negedge rst_n_int) begin
		if (!rst_n_int) begin
			brk_reg <= 1'b0;
		end else begin
			brk_reg <= pins.break_frame_request; // RULE13
		end
	end
	assign O_BREAK_REQ = brk_reg;

	// Address receiver. Line low on strap bit 0 means a one.
	logic                   ser_in;
	nac_pkg::nac_ser_t      rx_st_reg,   rx_st_next;
	logic [7:0]             rx_cnt_reg,  rx_cnt_next;
	logic [2:0]             rx_bit_reg,  rx_bit_next;
	logic [`NAC_ADDR_W-1:0] rx_sh_reg,   rx_sh_next;
	logic [`NAC_ADDR_W-1:0] last_reg,    last_next;
	logic                   have_reg,    have_next;
	logic [`NAC_ADDR_W-1:0] addr_reg,    addr_next;
	logic                   valid_reg,   valid_next;
	logic                   frame_ok;
	logic                   accept;

	assign ser_in = ~pins.addr_strap_n[0]; // RULE8

	always_comb begin
		rx_st_next  = rx_st_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next  = rx_sh_reg;
		last_next   = last_reg;
		have_next   = have_reg;
		addr_next   = addr_reg;
		valid_next  = valid_reg;
		frame_ok    = 1'b0;
		accept      = 1'b0;
		if (pins.addr_method_select) begin
			addr_next   = ~pins.addr_strap_n; // RULE6 RULE7
			valid_next  = 1'b1;
			have_next   = 1'b0;
			rx_st_next  = nac_pkg::NAC_IDLE;
			rx_cnt_next = 8'h00;
		end else if (tick) begin // RULE3
			unique case (rx_st_reg)
				nac_pkg::NAC_IDLE: begin
					if (ser_in) begin
						rx_st_next  = nac_pkg::NAC_START;
						rx_cnt_next = 8'h00;
					end
				end
				nac_pkg::NAC_START: begin
					// Mid-bit check rejects glitches on the idle line
					if (rx_cnt_reg == HALF_M1) begin
						rx_cnt_next = 8'h00;
						rx_bit_next = 3'h0;
						rx_st_next  = ser_in ? nac_pkg::NAC_DATA : nac_pkg::NAC_IDLE;
					end else begin
						rx_cnt_next = rx_cnt_reg + 8'h01;
					end
				end
				nac_pkg::NAC_DATA: begin
					if (rx_cnt_reg == BIT_M1) begin
						rx_cnt_next = 8'h00;
						rx_sh_next  = {ser_in, rx_sh_reg[`NAC_ADDR_W-1:1]};
						if (rx_bit_reg == DATA_LAST) begin
							rx_st_next = nac_pkg::NAC_STOP;
						end else begin
							rx_bit_next = rx_bit_reg + 3'h1;
						end
					end else begin
						rx_cnt_next = rx_cnt_reg + 8'h01;
					end
				end
				nac_pkg::NAC_STOP: begin
					if (rx_cnt_reg == BIT_M1) begin
						rx_cnt_next = 8'h00;
						rx_st_next  = nac_pkg::NAC_IDLE;
						if (!ser_in) begin
							frame_ok = 1'b1;
						end else begin
							have_next = 1'b0; // RULE11
						end
					end else begin
						rx_cnt_next = rx_cnt_reg + 8'h01;
					end
				end
			endcase
			if (frame_ok) begin
				// One frame alone never moves the address
				accept    = have_reg && (rx_sh_reg == last_reg); // RULE11 RULE16
				last_next = rx_sh_reg;
				have_next = 1'b1;
				if (accept) begin
					addr_next  = rx_sh_reg + 6'h01; // RULE9
					valid_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge I_CLK or negedge rst_n_int) begin
		if (!rst_n_int) begin
			rx_st_reg  <= nac_pkg::NAC_IDLE;
			rx_cnt_reg <= 8'h00;
			rx_bit_reg <= 3'h0;
			rx_sh_reg  <= `NAC_ADDR_RST;
			last_reg   <= `NAC_ADDR_RST;
			have_reg   <= 1'b0; // RULE16
			addr_reg   <= `NAC_ADDR_RST;
			valid_reg  <= 1'b0;
		end else begin
			rx_st_reg  <= rx_st_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bit_reg <= rx_bit_next;
			rx_sh_reg  <= rx_sh_next;
			last_reg   <= last_next;
			have_reg   <= have_next;
			addr_reg   <= addr_next;
			valid_reg  <= valid_next;
		end
	end
	assign O_NODE_ADDR  = addr_reg;
	assign O_ADDR_VALID = valid_reg;

	// Chain transmitter: gap, start, six data bits LSB first, stop, repeat
	nac_pkg::nac_ser_t      tx_st_reg,  tx_st_next;
	logic [7:0]             tx_cnt_reg, tx_cnt_next;
	logic [2:0]             tx_bit_reg, tx_bit_next;
	logic [`NAC_ADDR_W-1:0] tx_sh_reg,  tx_sh_next;
	logic                   out_n_reg,  out_n_next;
	logic                   strobe_reg, strobe_next;
	logic                   bit_end;

	always_comb begin
		tx_st_next  = tx_st_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_bit_next = tx_bit_reg;
		tx_sh_next  = tx_sh_reg;
		bit_end     = tick && (tx_cnt_reg == BIT_M1);
		strobe_next = bit_end; // RULE3
		if (tick) begin
			tx_cnt_next = bit_end ? 8'h00 : tx_cnt_reg + 8'h01;
		end
		if (bit_end) begin
			unique case (tx_st_reg)
				nac_pkg::NAC_IDLE: begin
					if (tx_bit_reg == GAP_M1) begin
						tx_st_next  = nac_pkg::NAC_START;
						tx_bit_next = 3'h0;
						tx_sh_next  = addr_reg + 6'h01; // RULE14
					end else begin
						tx_bit_next = tx_bit_reg + 3'h1;
					end
				end
				nac_pkg::NAC_START: begin
					tx_st_next  = nac_pkg::NAC_DATA;
					tx_bit_next = 3'h0;
				end
				nac_pkg::NAC_DATA: begin
					tx_sh_next = {1'b0, tx_sh_reg[`NAC_ADDR_W-1:1]};
					if (tx_bit_reg == DATA_LAST) begin
						tx_st_next = nac_pkg::NAC_STOP;
					end else begin
						tx_bit_next = tx_bit_reg + 3'h1;
					end
				end
				nac_pkg::NAC_STOP: begin
					tx_st_next  = nac_pkg::NAC_IDLE;
					tx_bit_next = 3'h0;
				end
			endcase
		end
		unique case (tx_st_next)
			nac_pkg::NAC_START: out_n_next = 1'b0; // RULE12
			nac_pkg::NAC_DATA:  out_n_next = ~tx_sh_next[0];
			nac_pkg::NAC_IDLE,
			nac_pkg::NAC_STOP:  out_n_next = 1'b1;
		endcase
	end

	always_ff @(posedge I_CLK or negedge rst_n_int) begin
		if (!rst_n_int) begin
			tx_st_reg  <= nac_pkg::NAC_IDLE;
			tx_cnt_reg <= 8'h00;
			tx_bit_reg <= 3'h0;
			tx_sh_reg  <= `NAC_ADDR_RST;
			out_n_reg  <= 1'b1;
			strobe_reg <= 1'b0;
		end else begin
			tx_st_reg  <= tx_st_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_bit_reg <= tx_bit_next;
			tx_sh_reg  <= tx_sh_next;
			out_n_reg  <= out_n_next;
			strobe_reg <= strobe_next;
		end
	end
	assign O_ADDR_CHAIN_OUT_N = out_n_reg;
	assign O_BIT_STROBE       = strobe_reg;

	default clocking @(posedge I_CLK); endclocking
	default disable iff (!rst_n_int);

	a_par_addr: assert property (pins.addr_method_select // RULE7
		|=> addr_reg == ~$past(pins.addr_strap_n))
		else $error("Parallel address does not follow inverted straps");
	a_strap_max: assert property (pins.addr_method_select && pins.addr_strap_n == 6'h00
		|=> addr_reg == `NAC_ADDR_MAX) // RULE6
		else $error("All straps low did not give the highest address");
	a_confirm_plus1: assert property (accept |=> addr_reg == $past(rx_sh_reg) + 6'h01) // RULE9
		else $error("Confirmed address is not received value plus one");
	a_need_two: assert property (frame_ok && !have_reg && !pins.addr_method_select
		|=> $stable(addr_reg)) // RULE11
		else $error("Address moved on a single frame");
	a_hold_addr: assert property (!pins.addr_method_select && !accept |=> $stable(addr_reg)) // RULE16
		else $error("Serial address changed without confirmation");
	a_chain_wrap: assert property (bit_end && tx_st_reg == nac_pkg::NAC_IDLE
		&& tx_bit_reg == GAP_M1 && addr_reg == `NAC_ADDR_MAX |=> tx_sh_reg == 6'h00) // RULE14
		else $error("Chain value did not wrap to zero");
	a_chain_start: assert property ($rose(tx_st_reg == nac_pkg::NAC_START)
		|-> !O_ADDR_CHAIN_OUT_N [*2]) // RULE12
		else $error("Chain start bit is not driven low");
	a_break_follow: assert property (pins.break_frame_request |=> O_BREAK_REQ) // RULE13
		else $error("Break request not passed on");
	// Slow reference: the bit counter must move on every clock edge
	a_slow_tick: assert property (!pins.clk_rate_select // RULE1
		|=> tx_cnt_reg != $past(tx_cnt_reg))
		else $error("Slow rate does not tick every cycle");
	a_strobe_slow: assert property (!pins.clk_rate_select [*8] ##0 O_BIT_STROBE
		|-> ##1 !O_BIT_STROBE [*2]) // RULE3
		else $error("Bit strobe too frequent");
	a_rst_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!rst_n_int |-> !have_reg && addr_reg == `NAC_ADDR_RST) // RULE4
		else $error("Internal reset did not clear address state");

	c_accept: cover property (accept);
	c_parallel: cover property (pins.addr_method_select && O_ADDR_VALID);
	c_fast: cover property (pins.clk_rate_select && O_BIT_STROBE);
	c_tx_frame: cover property (tx_st_reg == nac_pkg::NAC_STOP && bit_end);

endmodule

/* File: tb/nac_chain_src.sv */
/*
 Model of the previous node's address chain output, seen as a serial line.
 Assumes the bench calls send just after a rising edge and picks the bit length.
*/
`timescale 1ns/1ps

module nac_chain_src (
	input  wire logic i_clk,
	output logic      o_line
);
	// Line rests high between frames, as the stop level
	initial o_line = 1'b1;

	// Start low, six bits low-first with a low line meaning one, then stop high
	task automatic send(input logic [5:0] v, input int bit_cyc);
		logic [7:0] fr;
		fr = {1'b1, ~v, 1'b0};
		for (int i = 0; i < 8; i++) begin
			o_line = fr[i];
			repeat (bit_cyc) @(posedge i_clk);
			#1;
		end
	endtask

	// Same frame with a low stop bit, then the line rests high for two bits
	task automatic send_bad(input logic [5:0] v, input int bit_cyc);
		logic [7:0] fr;
		fr = {1'b0, ~v, 1'b0};
		for (int i = 0; i < 8; i++) begin
			o_line = fr[i];
			repeat (bit_cyc) @(posedge i_clk);
			#1;
		end
		o_line = 1'b1;
		repeat (2 * bit_cyc) @(posedge i_clk);
		#1;
	endtask
endmodule

/* File: tb/nac_node_cfg_tb.sv */
/*
 Self-checking bench of the node address and clock setup block.
 Assumes the design package and the chain source model are compiled first.
*/
`timescale 1ns/1ps

`define NAC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module nac_node_cfg_tb;
	localparam int BT = 4;
	localparam int GB = 8;
	logic               I_CLK;
	logic               I_RST_N;
	logic               line;
	nac_pkg::nac_pins_t pins;
	logic [5:0]         strap_n;
	logic [5:0]         v;
	logic [5:0]         O_NODE_ADDR;
	logic               O_WORK_CLK;
	logic               O_FAST_RATE;
	logic               O_RST_N;
	logic               O_ADDR_VALID;
	logic               O_ADDR_CHAIN_OUT_N;
	logic               O_BIT_STROBE;
	logic               O_BREAK_REQ;
	logic [6:0]         exp_q;
	int                 error_cnt;
	int                 cmp_count;
	int                 n;
	logic [6:0]         notes[$];
	event               look;

	// Serial mode grounds straps 1 to 5 and feeds the chain on bit 0
	assign strap_n = pins.addr_method_select ? pins.addr_strap_n : {5'h00, line};

	nac_node_cfg #(.BIT_TICKS(BT), .GAP_BITS(GB)) i_nac_node_cfg (
		.I_CLK                (I_CLK),
		.I_RST_N              (I_RST_N),
		.I_CLK_RATE_SELECT    (pins.clk_rate_select),
		.I_ADDR_METHOD_SELECT (pins.addr_method_select),
		.I_ADDR_STRAP_N       (strap_n),
		.I_BREAK_FRAME_REQUEST(pins.break_frame_request),
		.O_WORK_CLK           (O_WORK_CLK),
		.O_FAST_RATE          (O_FAST_RATE),
		.O_RST_N              (O_RST_N),
		.O_NODE_ADDR          (O_NODE_ADDR),
		.O_ADDR_VALID         (O_ADDR_VALID),
		.O_ADDR_CHAIN_OUT_N   (O_ADDR_CHAIN_OUT_N),
		.O_BIT_STROBE         (O_BIT_STROBE),
		.O_BREAK_REQ          (O_BREAK_REQ)
	);

	nac_chain_src i_nac_chain_src (
		.i_clk (I_CLK),
		.o_line(line)
	);

	initial begin
		I_CLK = 1'b0;
		forever #2 I_CLK = ~I_CLK;
	end

	task automatic tick(input int c);
		repeat (c) @(posedge I_CLK);
		#1;
	endtask

	task automatic note(input logic [6:0] e);
		notes.push_back(e);
		->look;
	endtask

	initial forever begin
		@look;
		exp_q = notes.pop_front();
		`NAC_CHK({O_ADDR_VALID, O_NODE_ADDR}, exp_q)
	end

	task automatic do_reset(input logic fast, input logic par);
		logic [12:0] r;
		I_RST_N = 1'b0;
		pins.clk_rate_select = fast;
		pins.addr_method_select = par;
		tick(16);
		r = {O_RST_N, O_FAST_RATE, O_ADDR_VALID, O_NODE_ADDR, O_ADDR_CHAIN_OUT_N,
		     O_BIT_STROBE, O_WORK_CLK, O_BREAK_REQ};
		`NAC_CHK(r, 13'h0008)
		I_RST_N = 1'b1;
		tick(8);
		`NAC_CHK(O_RST_N, 1'b1)
	endtask

	task automatic work(input logic fast);
		logic p;
		p = O_WORK_CLK;
		for (int i = 0; i < 6; i++) begin
			tick(1);
			`NAC_CHK({O_FAST_RATE, O_WORK_CLK}, {fast, fast ? ~p : 1'b0})
			p = O_WORK_CLK;
		end
	endtask

	// Chain bit period must stay one reference bit whatever the rate strap
	task automatic strobes(input int bc);
		n = 0;
		for (int i = 0; i < 10 * bc; i++) begin
			tick(1);
			n += O_BIT_STROBE;
		end
		`NAC_CHK(n, 10)
	endtask

	// A high run longer than any run inside a frame marks the next fall as a start
	task automatic chain(input int bc, input logic [5:0] e);
		logic [5:0] got;
		n = 0;
		while (n < 7 * bc) begin
			tick(1);
			n = O_ADDR_CHAIN_OUT_N ? n + 1 : 0;
		end
		while (O_ADDR_CHAIN_OUT_N) tick(1);
		tick(bc / 2);
		for (int i = 0; i < 6; i++) begin
			tick(bc);
			got[i] = ~O_ADDR_CHAIN_OUT_N;
		end
		tick(bc);
		`NAC_CHK({got, O_ADDR_CHAIN_OUT_N}, {e, 1'b1})
	endtask

	task automatic parallel(input logic fast);
		int bc;
		bc = fast ? 2 * BT : BT;
		do_reset(fast, 1'b1);
		work(fast);
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
			pins.addr_strap_n = v;
			tick(3);
			note({1'b1, ~v});
		end
		for (int i = 0; i < 2; i++) begin
			v = i ? 6'($urandom) : 6'h00;
			pins.addr_strap_n = v;
			tick(20 * bc);
			chain(bc, ~v + 6'h1);
		end
	endtask

	task automatic serial(input logic fast);
		int bc;
		logic [5:0] w;
		bc = fast ? 2 * BT : BT;
		do_reset(fast, 1'b0);
		work(fast);
		strobes(bc);
		// Bit 0 clear keeps the first value apart from the 6'h3f frame sent just before it
		v = 6'($urandom) & 6'h3e;
		w = v ^ 6'h15;
		i_nac_chain_src.send(6'h3f, bc);
		tick(2 * bc);
		note(7'h00);
		i_nac_chain_src.send(v, bc);
		tick(2 * bc);
		note(7'h00);
		i_nac_chain_src.send(v, bc);
		tick(2 * bc);
		note({1'b1, v + 6'h1});
		i_nac_chain_src.send(w, bc);
		tick(2 * bc);
		note({1'b1, v + 6'h1});
		// A low stop drops the pending match, so the next copy counts as a first one
		i_nac_chain_src.send_bad(w, bc);
		i_nac_chain_src.send(w, bc);
		tick(2 * bc);
		note({1'b1, v + 6'h1});
		i_nac_chain_src.send(w, bc);
		i_nac_chain_src.send(6'h3f, bc);
		tick(2 * bc);
		note({1'b1, w + 6'h1});
		i_nac_chain_src.send(6'h3f, bc);
		tick(2 * bc);
		note(7'h40);
		chain(bc, 6'h01);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge I_CLK);
		error_cnt++;
		$display("watchdog expired");
		test_done();
	end

	initial begin
		I_RST_N = 1'b0;
		pins = {3'b010, 6'h3f};
		error_cnt = 0;
		cmp_count = 0;
		void'($urandom(32'hce2e4487));
		parallel(1'b0);
		$display("parallel slow done");
		parallel(1'b1);
		$display("parallel fast done");
		serial(1'b0);
		$display("serial slow done");
		serial(1'b1);
		$display("serial fast done");
		pins.break_frame_request = 1'b1;
		tick(3);
		`NAC_CHK(O_BREAK_REQ, 1'b1)
		pins.break_frame_request = 1'b0;
		tick(2);
		`NAC_CHK(O_BREAK_REQ, 1'b1)
		tick(1);
		`NAC_CHK(O_BREAK_REQ, 1'b0)
		$display("break done");
		test_done();
	end
endmodule
